// >>> rtl/rmc_pkg.sv
// Purpose: Shared constants and mode type for the radio mode controller.
// Assumes: core_clk at 100 MHz, asynchronous active-low reset.
// Notes: Contract
// Contract
// - Power-up bit low forces power down regardless of other inputs.
// - Power down keeps stored data and host access alive.
// - Power-up bit high moves power down into standby-I.
// - Active modes need chip enable high; chip enable low returns to standby-I.
// - Transmitter role, chip enable high, empty TX FIFO gives standby-II.
// - Standby-II packet load starts synthesizer; transmit after settling delay.
// - RX mode only with power-up, receiver role and chip enable high.
// - RX stores payloads only with matching address and good CRC.
// - Full RX FIFO drops new valid packets, never overwrites.
// - RX persists until host selects standby-I or power down.
// - RX shows signed received power, clamped to minus 100..plus 10.
// - TX entry needs power-up, transmitter role, payload, qualified chip enable pulse.
// - TX held until packet sent; then standby-I if chip enable low.
// - Chip enable high after packet: next packet if any, else standby-II.
// - Chip enable held high drains the FIFO and follows refills.
// - Standby-II sends once chip select rises after an upload.
// - A minimum chip enable pulse sends exactly one entry then standby-I.
// - Power-up high, chip enable low, no transmission gives standby-I.
// - Standby to active and TX to RX changes finish within settling time.

package rmc_pkg;

  // Clock and timing figures.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_US = 210;
  localparam int SETTLE_CYC = (SETTLE_US * 1000) / CLK_PERIOD_NS;
  localparam int CE_MIN_NS = 10000;
  localparam int CE_MIN_CYC = (CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 15;
  localparam int CE_CNT_W = 11;

  // Receive storage shape.
  localparam int PAYLOAD_W = 256;
  localparam int RX_SLOTS = 3;
  localparam int SLOT_CNT_W = 2;
  localparam int SLOT_IDX_W = 2;

  // Received power reading format and limits.
  localparam int PWR_LVL_W = 8;
  localparam logic [7:0] PWR_LVL_MIN = 8'h9c;
  localparam logic [7:0] PWR_LVL_MAX = 8'h0a;
  localparam logic [7:0] PWR_LVL_RESET = 8'h9c;

  // Operating modes, one-hot.
  typedef enum logic [6:0] {
    ST_PDN = 7'h01,
    ST_SB1 = 7'h02,
    ST_SB2 = 7'h04,
    ST_STX = 7'h08,
    ST_TX = 7'h10,
    ST_SRX = 7'h20,
    ST_RX = 7'h40
  } rmc_mode_t;

endpackage : rmc_pkg

// >>> rtl/rmc_pin_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels from outside the core_clk domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module rmc_pin_sync
  import rmc_pkg::*;
#(
  parameter int W = 2
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Pin levels in and synchronised levels out.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flops in series settle any metastability.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule : rmc_pin_sync

// >>> rtl/rmc_rx_slots.sv
// Purpose: Three-slot store for received payloads.
// Assumes: Write and read strobes are single-cycle pulses on core_clk.
// Notes: Contents survive every mode change; only reset or host pops empty the slots.
`timescale 1ns/1ns
module rmc_rx_slots
  import rmc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Write side from the packet validator.
  input wire logic wr_valid,
  input wire logic [PAYLOAD_W-1:0] wr_data,
  output logic wr_drop,
  // Read side toward the host.
  input wire logic rd_pop,
  output logic [PAYLOAD_W-1:0] rd_data,
  output logic slots_full,
  output logic slots_empty
);

  logic [PAYLOAD_W-1:0] mem [0:RX_SLOTS-1];
  logic [SLOT_IDX_W-1:0] wr_ptr_q;
  logic [SLOT_IDX_W-1:0] rd_ptr_q;
  logic [SLOT_CNT_W-1:0] count_q;
  logic [PAYLOAD_W-1:0] rd_data_q;
  wire accept;
  wire pop;

  function automatic logic [SLOT_IDX_W-1:0] bump(input logic [SLOT_IDX_W-1:0] p);
    bump = (p == SLOT_IDX_W'(RX_SLOTS - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // A full store refuses the packet instead of overwriting a slot.
  assign slots_full = (count_q == SLOT_CNT_W'(RX_SLOTS));
  assign slots_empty = (count_q == '0);
  assign accept = wr_valid && !slots_full;
  assign wr_drop = wr_valid && slots_full;
  assign pop = rd_pop && !slots_empty;
  assign rd_data = rd_data_q;

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (accept) wr_ptr_q <= bump(wr_ptr_q);
      if (pop) rd_ptr_q <= bump(rd_ptr_q);
      count_q <= count_q + SLOT_CNT_W'(accept) - SLOT_CNT_W'(pop);
    end
  end

  // Payload storage needs no reset.
  always_ff @(posedge core_clk) begin
    if (accept) mem[wr_ptr_q] <= wr_data;
  end

  // Head slot is presented from a flop.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rd_data_q <= '0;
    else rd_data_q <= mem[pop ? bump(rd_ptr_q) : rd_ptr_q];
  end

  no_overwrite_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    slots_full && wr_valid && !pop |=> slots_full && $stable(wr_ptr_q))
    else $error("full store accepted a packet");

endmodule : rmc_rx_slots

// >>> rtl/rmc_mode_ctrl.sv
// Purpose: Operating-mode state machine of the packet transceiver.
// Assumes: Config bits and FIFO status are on core_clk; chip enable and chip select are pins.
// Notes: The settling count is a parameter so simulations can shorten it.
`timescale 1ns/1ns
module rmc_mode_ctrl
  import rmc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Configuration bits held by the register file.
  input wire logic power_on_bit,
  input wire logic receiver_role_bit,
  // Host pins.
  input wire logic chip_enable_pin,
  input wire logic spi_csn_b_pin,
  // Transmit FIFO status and transmit engine.
  input wire logic tx_fifo_empty,
  input wire logic tx_packet_done,
  output logic tx_start,
  // Receive path from the packet engine.
  input wire logic rx_packet_strobe,
  input wire logic rx_addr_match,
  input wire logic rx_crc_ok,
  input wire logic [PAYLOAD_W-1:0] rx_payload,
  output logic rx_packet_dropped,
  // Receive FIFO toward the host.
  input wire logic rx_fifo_pop,
  output logic [PAYLOAD_W-1:0] rx_fifo_data,
  output logic rx_fifo_full,
  output logic rx_fifo_empty,
  // Received power.
  input wire logic [PWR_LVL_W-1:0] rx_power_raw,
  output logic [PWR_LVL_W-1:0] received_power_level,
  // Mode and analog enables.
  output logic [6:0] current_mode,
  output logic xtal_buffers_on,
  output logic synth_on,
  output logic rx_enable
);

  rmc_mode_t mode_q;
  rmc_mode_t mode_d;
  logic [SETTLE_W-1:0] settle_q;
  logic [CE_CNT_W-1:0] ce_cnt_q;
  logic arm_q;
  logic tx_start_q;
  logic [PWR_LVL_W-1:0] pwr_lvl_q;
  logic [1:0] pins_s;
  logic ce_s;
  logic csn_s;
  logic csn_q;
  logic csn_rise;
  logic ce_long;
  logic settle_done;
  logic settling;
  logic tx_again;
  logic rx_store;
  logic [PWR_LVL_W-1:0] pwr_lvl_clamped;

  // Chip enable and chip select cross into core_clk here.
  rmc_pin_sync #(
    .W(2)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in({spi_csn_b_pin, chip_enable_pin}),
    .pin_sync(pins_s)
  );

  // Decoded conditions.
  assign ce_s = pins_s[0];
  assign csn_s = pins_s[1];
  assign csn_rise = csn_s && !csn_q;
  assign ce_long = (ce_cnt_q == CE_CNT_W'(CE_MIN_CYC));
  assign settling = (mode_q == ST_STX) || (mode_q == ST_SRX);
  assign settle_done = (settle_q == SETTLE_W'(SETTLE_CYCLES - 1));
  assign tx_again = tx_packet_done && ce_s && !receiver_role_bit && !tx_fifo_empty;
  assign rx_store = (mode_q == ST_RX) && rx_packet_strobe && rx_addr_match && rx_crc_ok;

  // Next mode.
  always_comb begin
    mode_d = mode_q;
    if (!power_on_bit) begin
      mode_d = ST_PDN;
    end else begin
      unique case (mode_q)
        ST_PDN: begin
          mode_d = ST_SB1;
        end
        ST_SB1: begin
          if (ce_s && receiver_role_bit) begin
            mode_d = ST_SRX;
          end else if (!receiver_role_bit && !tx_fifo_empty && arm_q) begin
            mode_d = ST_STX;
          end else if (ce_long && !receiver_role_bit && tx_fifo_empty) begin
            mode_d = ST_SB2;
          end
        end
        ST_SB2: begin
          if (!ce_s) begin
            mode_d = ST_SB1;
          end else if (receiver_role_bit) begin
            mode_d = ST_SRX;
          end else if (!tx_fifo_empty && csn_rise) begin
            mode_d = ST_STX;
          end
        end
        ST_STX: begin
          if (settle_done) mode_d = ST_TX;
        end
        ST_TX: begin
          if (tx_packet_done) begin
            if (!ce_s) begin
              mode_d = ST_SB1;
            end else if (receiver_role_bit) begin
              mode_d = ST_SRX;
            end else if (tx_fifo_empty) begin
              mode_d = ST_SB2;
            end
          end
        end
        ST_SRX: begin
          if (!ce_s || !receiver_role_bit) mode_d = ST_SB1;
          else if (settle_done) mode_d = ST_RX;
        end
        ST_RX: begin
          if (!ce_s || !receiver_role_bit) mode_d = ST_SB1;
        end
        default: begin
          mode_d = ST_PDN;
        end
      endcase
    end
  end

  // Mode register.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) mode_q <= ST_PDN;
    else mode_q <= mode_d;
  end

  // Settling timer runs only in the two transition modes.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) settle_q <= '0;
    else if (settling && !settle_done) settle_q <= settle_q + 1'b1;
    else settle_q <= '0;
  end

  // Previous chip select level; a rise ends an upload and starts a send in standby-II.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) csn_q <= 1'b1;
    else csn_q <= csn_s;
  end

  // Chip enable high time, saturating at the minimum pulse.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ce_cnt_q <= '0;
    else if (!ce_s) ce_cnt_q <= '0;
    else if (!ce_long) ce_cnt_q <= ce_cnt_q + 1'b1;
  end

  // A qualified pulse arms one transmission, even after chip enable falls.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) arm_q <= 1'b0;
    else if (!power_on_bit || mode_d == ST_STX) arm_q <= 1'b0;
    else if (ce_long) arm_q <= 1'b1;
  end

  // Transmit start pulses on settle end and on back-to-back packets.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) tx_start_q <= 1'b0;
    else tx_start_q <= power_on_bit &&
      ((mode_q == ST_STX && settle_done) || (mode_q == ST_TX && tx_again));
  end

  // Received power is clamped to its range and follows only in RX.
  assign pwr_lvl_clamped = ($signed(rx_power_raw) < $signed(PWR_LVL_MIN)) ? PWR_LVL_MIN :
                   ($signed(rx_power_raw) > $signed(PWR_LVL_MAX)) ? PWR_LVL_MAX : rx_power_raw;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) pwr_lvl_q <= PWR_LVL_RESET;
    else if (mode_q == ST_RX) pwr_lvl_q <= pwr_lvl_clamped;
  end

  // Receive store is never cleared by mode changes.
  rmc_rx_slots u_rx_slots (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_valid(rx_store),
    .wr_data(rx_payload),
    .wr_drop(rx_packet_dropped),
    .rd_pop(rx_fifo_pop),
    .rd_data(rx_fifo_data),
    .slots_full(rx_fifo_full),
    .slots_empty(rx_fifo_empty)
  );

  // Outputs.
  assign tx_start = tx_start_q;
  assign received_power_level = pwr_lvl_q;
  assign current_mode = mode_q;
  assign xtal_buffers_on = (mode_q != ST_PDN) && (mode_q != ST_SB1);
  assign synth_on = settling || (mode_q == ST_TX) || (mode_q == ST_RX);
  assign rx_enable = (mode_q == ST_RX);

  // Checks on the mode machine.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  pdn_force_a: assert property (!power_on_bit |=> mode_q == ST_PDN)
    else $error("power-up low did not give power down");

  wake_sb1_a: assert property (
    mode_q == ST_PDN && power_on_bit |=> mode_q == ST_SB1)
    else $error("power-up did not give standby-I");

  rx_entry_a: assert property (
    mode_q != ST_SRX && mode_d == ST_SRX |-> power_on_bit && receiver_role_bit && ce_s)
    else $error("RX entered without all three enables");

  tx_entry_a: assert property (
    mode_q == ST_SB1 && mode_d == ST_STX |-> arm_q && !tx_fifo_empty && !receiver_role_bit)
    else $error("TX entered without a qualified pulse");

  settle_time_a: assert property (
    mode_q == ST_STX && !settle_done && power_on_bit
    |=> mode_q == ST_STX && settle_q == $past(settle_q) + 1'b1)
    else $error("settling count did not advance");

  settle_end_a: assert property (
    mode_q == ST_STX && settle_done && power_on_bit |=> mode_q == ST_TX && tx_start)
    else $error("settling end did not start TX");

  tx_hold_a: assert property (
    mode_q == ST_TX && !tx_packet_done && power_on_bit |=> mode_q == ST_TX)
    else $error("TX left before packet done");

  ce_low_a: assert property (
    (mode_q == ST_RX || mode_q == ST_SB2) && !ce_s && power_on_bit |=> mode_q == ST_SB1)
    else $error("chip enable low did not give standby-I");

  tx_next_a: assert property (
    mode_q == ST_TX && tx_again && power_on_bit |=> tx_start && mode_q == ST_TX)
    else $error("next packet not started");

  pwr_range_a: assert property (
    mode_q == ST_RX |=> $signed(received_power_level) >= $signed(PWR_LVL_MIN) &&
      $signed(received_power_level) <= $signed(PWR_LVL_MAX))
    else $error("received power out of range");

  one_shot_a: assert property (
    mode_q == ST_TX && tx_packet_done && !ce_s && power_on_bit |=> mode_q == ST_SB1 && !tx_start)
    else $error("pulse mode sent more than one packet");

endmodule : rmc_mode_ctrl

// >>> sim/rmc_host_model.sv
// Purpose: Host and transmit engine stand-in facing the mode controller.
// Assumes: Bench calls the tasks just after a rising clock edge.
// Notes: Oscillator start-up wait is shortened to keep runs brief.
`timescale 1ns/1ns
module rmc_host_model
  import rmc_pkg::*;
#(
  parameter int START_WAIT = 50,
  parameter int AIR_CYC = 30
) (
  // Clock.
  input wire logic core_clk,
  // Host pins.
  output logic chip_enable_pin,
  output logic spi_csn_b_pin,
  // Transmit FIFO and engine.
  input wire logic tx_start,
  output logic tx_fifo_empty,
  output logic tx_packet_done
);
  int tx_count = 0;
  int sent = 0;

  // Pins idle low and deselected.
  initial begin
    chip_enable_pin = 1'b0;
    spi_csn_b_pin = 1'b1;
    tx_packet_done = 1'b0;
  end

  assign tx_fifo_empty = (tx_count == 0);

  // Each start sends the head packet and pulses done after the air time.
  always @(posedge core_clk) begin
    if (tx_start === 1'b1) begin
      repeat (AIR_CYC) @(posedge core_clk);
      #1 tx_packet_done = 1'b1;
      tx_count--;
      sent++;
      @(posedge core_clk);
      #1 tx_packet_done = 1'b0;
    end
  end

  // Sets the chip enable level, waiting for the oscillator before a rise.
  task automatic ce_set(input logic v);
    if (v) repeat (START_WAIT) @(posedge core_clk);
    #1 chip_enable_pin = v;
  endtask : ce_set

  // Pulses chip enable high for n cycles, n above the minimum high time.
  task automatic ce_pulse(input int n);
    ce_set(1'b1);
    repeat (n) @(posedge core_clk);
    #1 chip_enable_pin = 1'b0;
  endtask : ce_pulse

  // Uploads one packet under chip select, well after any chip enable rise.
  task automatic upload();
    repeat (400) @(posedge core_clk);
    #1 spi_csn_b_pin = 1'b0;
    tx_count++;
    repeat (8) @(posedge core_clk);
    #1 spi_csn_b_pin = 1'b1;
  endtask : upload
endmodule : rmc_host_model

// >>> sim/radio_mode_controller_tb_top.sv
// Purpose: Self-checking bench for the radio mode controller.
// Assumes: Settling shortened to 20 cycles; inputs change 1 ns after edges.
// Notes: Host pins and transmit engine come from the host model.
`timescale 1ns/1ns
module radio_mode_controller_tb_top;
  import rmc_pkg::*;
  localparam int SETTLE = 20;
  logic core_clk, rst_b, power_on_bit, receiver_role_bit;
  logic chip_enable_pin, spi_csn_b_pin, tx_fifo_empty, tx_packet_done, tx_start;
  logic rx_packet_strobe, rx_addr_match, rx_crc_ok, rx_packet_dropped, rx_fifo_pop;
  logic [PAYLOAD_W-1:0] rx_payload, rx_fifo_data;
  logic rx_fifo_full, rx_fifo_empty, xtal_buffers_on, synth_on, rx_enable;
  logic [PWR_LVL_W-1:0] rx_power_raw, received_power_level;
  logic [6:0] current_mode;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  rmc_mode_ctrl #(.SETTLE_CYCLES(SETTLE)) rmc_mode_ctrl_inst (.core_clk(core_clk),
    .rst_b(rst_b), .power_on_bit(power_on_bit), .receiver_role_bit(receiver_role_bit),
    .chip_enable_pin(chip_enable_pin), .spi_csn_b_pin(spi_csn_b_pin),
    .tx_fifo_empty(tx_fifo_empty), .tx_packet_done(tx_packet_done), .tx_start(tx_start),
    .rx_packet_strobe(rx_packet_strobe), .rx_addr_match(rx_addr_match),
    .rx_crc_ok(rx_crc_ok), .rx_payload(rx_payload), .rx_packet_dropped(rx_packet_dropped),
    .rx_fifo_pop(rx_fifo_pop), .rx_fifo_data(rx_fifo_data), .rx_fifo_full(rx_fifo_full),
    .rx_fifo_empty(rx_fifo_empty), .rx_power_raw(rx_power_raw),
    .received_power_level(received_power_level), .current_mode(current_mode),
    .xtal_buffers_on(xtal_buffers_on), .synth_on(synth_on), .rx_enable(rx_enable));
  rmc_host_model rmc_host_model_inst (.core_clk(core_clk),
    .chip_enable_pin(chip_enable_pin), .spi_csn_b_pin(spi_csn_b_pin),
    .tx_start(tx_start), .tx_fifo_empty(tx_fifo_empty),
    .tx_packet_done(tx_packet_done));

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cuts a hang short once the cycle ceiling is reached.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [PAYLOAD_W-1:0] seen, input logic [PAYLOAD_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  // Waits a bounded number of cycles for a mode, then compares it.
  task automatic wait_mode(input logic [6:0] m, input int lim);
    for (int i = 0; i < lim && current_mode !== m; i++) step();
    check(current_mode, m);
  endtask : wait_mode

  // Presents one received packet; drop is seen in the same cycle.
  task automatic rx_pkt(input logic am, input logic ok, input logic [7:0] d,
                        input logic drop);
    rx_packet_strobe = 1'b1;
    rx_addr_match = am;
    rx_crc_ok = ok;
    rx_payload = {248'h0, d};
    #1 check(rx_packet_dropped, drop);
    step();
    rx_packet_strobe = 1'b0;
  endtask : rx_pkt

  task automatic print_verdict();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Main test sequence.
  initial begin
    logic [7:0] pw [3] = '{8'h80, 8'h7f, 8'hf6};
    logic [7:0] pe [3] = '{PWR_LVL_MIN, PWR_LVL_MAX, 8'hf6};
    {rst_b, power_on_bit, receiver_role_bit, rx_packet_strobe} = 4'h0;
    {rx_addr_match, rx_crc_ok, rx_fifo_pop} = 3'h0;
    rx_payload = '0;
    rx_power_raw = 8'h00;
    repeat (3) @(posedge core_clk);
    #1 rst_b = 1'b1;
    check(current_mode, ST_PDN);
    check(received_power_level, PWR_LVL_RESET);
    power_on_bit = 1'b1;
    wait_mode(ST_SB1, 4);
    check(xtal_buffers_on, 1'b0);
    power_on_bit = 1'b0;
    wait_mode(ST_PDN, 4);
    $display("test power done");
    power_on_bit = 1'b1;
    receiver_role_bit = 1'b1;
    rmc_host_model_inst.ce_set(1'b1);
    wait_mode(ST_SRX, 6);
    check(synth_on, 1'b1);
    wait_mode(ST_RX, SETTLE + 2);
    check(rx_enable, 1'b1);
    rx_pkt(1'b0, 1'b1, 8'h55, 1'b0);
    rx_pkt(1'b1, 1'b0, 8'h66, 1'b0);
    step();
    check(rx_fifo_empty, 1'b1);
    for (int i = 1; i <= 3; i++) rx_pkt(1'b1, 1'b1, 8'(i), 1'b0);
    step();
    check(rx_fifo_full, 1'b1);
    rx_pkt(1'b1, 1'b1, 8'h09, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rx_power_raw = pw[i];
      step();
      step();
      check(received_power_level, pe[i]);
    end
    repeat (50) step();
    check(current_mode, ST_RX);
    rmc_host_model_inst.ce_set(1'b0);
    wait_mode(ST_SB1, 6);
    power_on_bit = 1'b0;
    wait_mode(ST_PDN, 4);
    for (int i = 1; i <= 3; i++) begin
      check(rx_fifo_data, PAYLOAD_W'(i));
      rx_fifo_pop = 1'b1;
      step();
      rx_fifo_pop = 1'b0;
      step();
    end
    check(rx_fifo_empty, 1'b1);
    $display("test rx done");
    power_on_bit = 1'b1;
    receiver_role_bit = 1'b0;
    rmc_host_model_inst.upload();
    rmc_host_model_inst.upload();
    check(current_mode, ST_SB1);
    rmc_host_model_inst.ce_pulse(1005);
    wait_mode(ST_STX, 20);
    wait_mode(ST_TX, SETTLE + 2);
    check(tx_start, 1'b1);
    wait_mode(ST_SB1, 40);
    check(rmc_host_model_inst.sent, 1);
    $display("test pulse done");
    rmc_host_model_inst.upload();
    rmc_host_model_inst.ce_set(1'b1);
    wait_mode(ST_TX, 1100);
    wait_mode(ST_SB2, 120);
    check(rmc_host_model_inst.sent, 3);
    check(xtal_buffers_on, 1'b1);
    rmc_host_model_inst.upload();
    wait_mode(ST_STX, 6);
    wait_mode(ST_TX, SETTLE + 2);
    rmc_host_model_inst.ce_set(1'b0);
    wait_mode(ST_SB1, 40);
    check(rmc_host_model_inst.sent, 4);
    $display("test held done");
    print_verdict();
  end
endmodule : radio_mode_controller_tb_top
